// file: rtl/sad_decoder.sv
// system address decoder: code, sram and private system regions
`timescale 1ns/1ps
`include "sad_regs.svh"
module sad_decoder (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // configuration
   input wire logic large_flash_i,
   input wire logic isram_en_i,
   input wire logic cache_en_i,
   // request, master 0 core, master 1 dma
   input wire logic req_i,
   input wire logic master_i,
   input wire logic write_i,
   input wire logic excl_i,
   input wire sad_pkg::sad_size_t size_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   // code target
   output logic code_sel_o,
   // sram and mmr target
   output logic sram_sel_o,
   output logic mmr_sel_o,
   output logic [16:0] sram_addr_o,
   output logic sram_isram_o,
   // private system target
   output logic sys_sel_o,
   output logic ppb_sel_o,
   // common outgoing transfer
   output logic write_o,
   output logic [31:0] addr_o,
   output logic [31:0] wdata_o,
   output logic [3:0] byte_en_o,
   // response
   output logic done_o,
   output logic err_o,
   output logic excl_ok_o,
   output logic [31:0] rom_data_o,
   output sad_pkg::sad_target_t target_o
);
   import sad_pkg::*;

   // ***********************************
   // helpers
   // ***********************************
   function automatic logic in_range(input logic [31:0] a,
         input logic [31:0] lo, input logic [31:0] hi);
      in_range = a >= lo && a <= hi;
   endfunction

   function automatic logic [3:0] lanes(input sad_size_t s,
         input logic [1:0] a);
      case (s)
         SAD_SIZE_BYTE: lanes = 4'h1 << a;
         SAD_SIZE_HALF: lanes = a[1] ? 4'hC : 4'h3;
         SAD_SIZE_WORD: lanes = 4'hF;
         default: lanes = 4'h0;
      endcase
   endfunction

   // ***********************************
   // region decode
   // ***********************************
   wire logic [31:0] code_end = large_flash_i ? `SAD_CODE_END_LARGE
      : `SAD_CODE_END_SMALL;
   // code fetch region is core only
   wire logic hit_code = in_range(addr_i, `SAD_CODE_BASE, code_end)
      && !master_i;
   // data sram grows by one block when instruction sram is off
   wire logic [31:0] data_bytes = isram_en_i ? `SAD_DATA_BYTES
      : `SAD_DATA_BIG_BYTES;
   wire logic [31:0] isram_bytes = cache_en_i
      ? `SAD_BLOCK_BYTES - `SAD_CACHE_BYTES : `SAD_BLOCK_BYTES;
   wire logic [31:0] sram_off = addr_i - `SAD_SRAM_BASE;
   wire logic hit_sram_rgn = in_range(addr_i, `SAD_SRAM_BASE,
      `SAD_SRAM_END);
   wire logic hit_dsram = hit_sram_rgn && sram_off < data_bytes;
   wire logic hit_isram = hit_sram_rgn && isram_en_i
      && sram_off >= `SAD_ISRAM_OFFS
      && sram_off < `SAD_ISRAM_OFFS + isram_bytes;
   wire logic hit_mmr = hit_sram_rgn && sram_off
      >= `SAD_ISRAM_OFFS + `SAD_BLOCK_BYTES;
   wire logic hit_sys = in_range(addr_i, `SAD_SYS_BASE, `SAD_SYS_END);
   wire logic hit_ppb = hit_sys && addr_i < `SAD_PPB_END;
   wire logic hit_rom = in_range(addr_i, `SAD_ROM_BASE, `SAD_ROM_END);
   wire logic [3:0] be = lanes(size_i, addr_i[1:0]);
   wire logic misalign = (size_i == SAD_SIZE_HALF && addr_i[0])
      || (size_i == SAD_SIZE_WORD && addr_i[1:0] != 2'h0);
   wire logic bad_size = size_i == SAD_SIZE_BAD;
   // dma may not enter the private system region
   wire logic dma_block = master_i && hit_sys;
   wire logic rom_wr = hit_rom && write_i;
   wire logic hit_any = hit_code || hit_dsram || hit_isram || hit_mmr
      || hit_sys;
   wire logic fault = !hit_any || dma_block || rom_wr || bad_size
      || misalign || (hit_code && write_i);
   wire logic go = req_i && !fault;
   // sram and mmr accept both masters, both directions
   wire logic go_sram = go && (hit_dsram || hit_isram);
   wire logic go_mmr = go && hit_mmr;
   wire logic go_sys = go && hit_sys && !hit_ppb;
   wire logic go_ppb = go && hit_ppb;
   wire logic go_code = go && hit_code;
   wire logic [16:0] sram_idx = sram_off[16:0];

   wire sad_target_t tgt_w = !req_i || fault ? SAD_TGT_NONE
      : hit_code ? SAD_TGT_CODE
      : (hit_dsram || hit_isram) ? SAD_TGT_SRAM
      : hit_mmr ? SAD_TGT_MMR
      : hit_ppb ? SAD_TGT_PPB
      : hit_rom ? SAD_TGT_ROM
      : SAD_TGT_SYS;

   // ***********************************
   // exclusive monitor and rom table
   // ***********************************
   logic excl_ok_w;
   logic [31:0] rom_w;
   sad_excl_mon u_excl (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .acc_i(go_sram),
      .master_i(master_i),
      .write_i(write_i),
      .excl_i(excl_i),
      .addr_i(addr_i),
      .excl_ok_o(excl_ok_w)
   );
   sad_rom_table u_rom (
      .index_i(addr_i[11:2]),
      .data_o(rom_w)
   );

   // ***********************************
   // next values, one cycle answer
   // ***********************************
   wire logic write_next = go && write_i;
   wire logic isram_next = go_sram && hit_isram;
   // refused accesses drive no lanes
   wire logic [3:0] byte_en_next = go ? be : 4'h0;
   wire logic done_next = req_i;
   wire logic err_next = req_i && fault;
   // rom word only for a taken rom read
   wire logic [31:0] rom_next = go && hit_rom ? rom_w : 32'h0;

   // ***********************************
   // code and sram selects
   // ***********************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         code_sel_o <= 1'b0;
      end else begin
         code_sel_o <= go_code;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sram_sel_o <= 1'b0;
      end else begin
         sram_sel_o <= go_sram;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mmr_sel_o <= 1'b0;
      end else begin
         mmr_sel_o <= go_mmr;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sram_addr_o <= 17'h0;
      end else begin
         sram_addr_o <= sram_idx;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sram_isram_o <= 1'b0;
      end else begin
         sram_isram_o <= isram_next;
      end
   end

   // ***********************************
   // system selects
   // ***********************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sys_sel_o <= 1'b0;
      end else begin
         sys_sel_o <= go_sys;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ppb_sel_o <= 1'b0;
      end else begin
         ppb_sel_o <= go_ppb;
      end
   end

   // ***********************************
   // write qualifiers
   // ***********************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         write_o <= 1'b0;
      end else begin
         write_o <= write_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         byte_en_o <= 4'h0;
      end else begin
         byte_en_o <= byte_en_next;
      end
   end

   // ***********************************
   // address and data
   // ***********************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         addr_o <= 32'h0;
      end else begin
         addr_o <= addr_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wdata_o <= 32'h0;
      end else begin
         wdata_o <= wdata_i;
      end
   end

   // ***********************************
   // response flags
   // ***********************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= done_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         err_o <= 1'b0;
      end else begin
         err_o <= err_next;
      end
   end

   // ***********************************
   // read data and target
   // ***********************************
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rom_data_o <= 32'h0;
      end else begin
         rom_data_o <= rom_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         target_o <= SAD_TGT_NONE;
      end else begin
         target_o <= tgt_w;
      end
   end

   // excl result is already registered inside the monitor
   always_comb begin
      excl_ok_o = excl_ok_w;
   end
endmodule // sad_decoder

// file: rtl/sad_regs.svh
// address map and size constants for the system address decoder
`ifndef SAD_REGS_SVH
`define SAD_REGS_SVH
`define SAD_CODE_BASE      32'h0000_0000
`define SAD_CODE_END_LARGE 32'h0003_FFFF
`define SAD_CODE_END_SMALL 32'h0001_FC00
`define SAD_SRAM_BASE      32'h2000_0000
`define SAD_SRAM_END       32'h2004_7FFF
`define SAD_SYS_BASE       32'hE000_0000
`define SAD_SYS_END        32'hF7FF_FFFF
`define SAD_PPB_END        32'hE004_0000
`define SAD_ROM_BASE       32'hE00F_F000
`define SAD_ROM_END        32'hE00F_FFFF
`define SAD_BLOCK_BYTES    32'h0000_8000
`define SAD_CACHE_BYTES    32'h0000_1000
`define SAD_DATA_BYTES     32'h0000_8000
`define SAD_DATA_BIG_BYTES 32'h0001_0000
`define SAD_ISRAM_OFFS     32'h0001_0000
`endif

// file: rtl/sad_pkg.sv
// types shared by the system address decoder
package sad_pkg;
   typedef enum logic [2:0] {
      SAD_TGT_NONE,
      SAD_TGT_CODE,
      SAD_TGT_SRAM,
      SAD_TGT_MMR,
      SAD_TGT_PPB,
      SAD_TGT_ROM,
      SAD_TGT_SYS
   } sad_target_t;
   typedef enum logic [1:0] {
      SAD_SIZE_BYTE,
      SAD_SIZE_HALF,
      SAD_SIZE_WORD,
      SAD_SIZE_BAD
   } sad_size_t;
endpackage

// file: rtl/sad_excl_mon.sv
// global exclusive access monitor for the sram region
`timescale 1ns/1ps
`include "sad_regs.svh"
module sad_excl_mon (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // access observed on the sram port
   input wire logic acc_i,
   input wire logic master_i,
   input wire logic write_i,
   input wire logic excl_i,
   input wire logic [31:0] addr_i,
   // exclusive store result
   output logic excl_ok_o
);
   logic [1:0] valid_reg;
   logic [1:0] valid_next;
   logic [29:0] tag_reg [2];
   logic [29:0] tag_next [2];
   wire logic [29:0] word = addr_i[31:2];
   wire logic own_hit = valid_reg[master_i] && tag_reg[master_i] == word;
   wire logic store_ok = acc_i && write_i && excl_i && own_hit;

   // reserve on exclusive load, clear on any store to the word
   always_comb begin
      valid_next = valid_reg;
      tag_next = tag_reg;
      if (acc_i && write_i) begin
         for (int m = 0; m < 2; m++) begin
            if (tag_reg[m] == word) begin
               valid_next[m] = 1'b0;
            end
         end
         if (excl_i) begin
            valid_next[master_i] = 1'b0;
         end
      end else if (acc_i && excl_i) begin
         valid_next[master_i] = 1'b1;
         tag_next[master_i] = word;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         valid_reg <= 2'h0;
         tag_reg <= '{30'h0, 30'h0};
         excl_ok_o <= 1'b0;
      end else begin
         valid_reg <= valid_next;
         tag_reg <= tag_next;
         excl_ok_o <= store_ok;
      end
   end
endmodule // sad_excl_mon

// file: rtl/sad_rom_table.sv
// read only debug component locator table
`timescale 1ns/1ps
module sad_rom_table #(
   parameter int ENTRIES = 4,
   parameter logic [31:0] ENTRY0 = 32'h0000_1001,
   parameter logic [31:0] ENTRY1 = 32'h0000_2001,
   parameter logic [31:0] ENTRY2 = 32'h0000_3001,
   parameter logic [31:0] ENTRY3 = 32'h0000_4001
) (
   // lookup
   input wire logic [9:0] index_i,
   output logic [31:0] data_o
);
   // entries are offsets to each debug block, zero ends the table
   wire logic [31:0] table_w [4] = '{ENTRY0, ENTRY1, ENTRY2, ENTRY3};
   assign data_o = (index_i < 10'(ENTRIES)) ? table_w[index_i[1:0]] : 32'h0;
endmodule // sad_rom_table

// file: sim/sad_decoder_chk.sv
// concurrent checks on the system address decoder ports
`timescale 1ns/1ps
module sad_decoder_chk (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // request
   input wire logic req_i,
   input wire logic master_i,
   input wire logic write_i,
   input wire sad_pkg::sad_size_t size_i,
   input wire logic [31:0] addr_i,
   // response
   input wire logic code_sel_o,
   input wire logic sram_sel_o,
   input wire logic ppb_sel_o,
   input wire logic [3:0] byte_en_o,
   input wire logic done_o,
   input wire logic err_o
);
   import sad_pkg::*;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   property p_done;
      req_i |=> done_o;
   endproperty
   a_done: assert property (p_done) else $error("no answer");
   property p_idle;
      !req_i |=> !done_o && !err_o;
   endproperty
   a_idle: assert property (p_idle) else $error("stray answer");
   property p_code;
      req_i && !master_i && !write_i && size_i == SAD_SIZE_WORD
         && addr_i < 32'h0001_FC00 && addr_i[1:0] == 2'h0 |=> code_sel_o;
   endproperty
   a_code: assert property (p_code) else $error("code miss");
   property p_cwr;
      req_i && write_i && addr_i < 32'h0004_0000 |=> err_o && !code_sel_o;
   endproperty
   a_cwr: assert property (p_cwr) else $error("code write taken");
   property p_sram;
      req_i && addr_i[31:15] == 17'h0_4000 && size_i == SAD_SIZE_BYTE
         |=> sram_sel_o && !err_o;
   endproperty
   a_sram: assert property (p_sram) else $error("sram miss");
   property p_dma;
      req_i && master_i && addr_i[31:18] == 14'h3800 |=> err_o && !ppb_sel_o;
   endproperty
   a_dma: assert property (p_dma) else $error("dma in window");
   property p_word;
      done_o && !err_o && $past(size_i) == SAD_SIZE_WORD |-> byte_en_o == 4'hF;
   endproperty
   a_word: assert property (p_word) else $error("word lanes");
   property p_mis;
      req_i && size_i == SAD_SIZE_HALF && addr_i[0] |=> err_o && !byte_en_o;
   endproperty
   a_mis: assert property (p_mis) else $error("misaligned taken");
   property p_unm;
      req_i && addr_i[31:28] == 4'h4 |=> err_o;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped taken");
   c_err: cover property (done_o && err_o);
   c_sram: cover property (sram_sel_o);
   c_ppb: cover property (ppb_sel_o);
endmodule // sad_decoder_chk
bind sad_decoder sad_decoder_chk u_sad_decoder_chk (.sys_clk_i, .rst_i,
   .req_i, .master_i, .write_i, .size_i, .addr_i, .code_sel_o, .sram_sel_o,
   .ppb_sel_o, .byte_en_o, .done_o, .err_o);

// file: sim/sad_master_model.sv
// core and dma requester stand-in
`timescale 1ns/1ps
module sad_master_model (
   // clock
   input wire logic sys_clk_i,
   // request
   output logic req_o,
   output logic master_o,
   output logic write_o,
   output logic excl_o,
   output sad_pkg::sad_size_t size_o,
   output logic [31:0] addr_o,
   output logic [31:0] wdata_o
);
   import sad_pkg::*;
   initial begin
      {req_o, master_o, write_o, excl_o} = 4'h0;
      size_o = SAD_SIZE_BYTE;
      addr_o = 32'h0;
      wdata_o = 32'h0;
   end
   // held over the taking edge, then released with lines scrambled
   task automatic xfer(input logic m, w, x, input sad_size_t s,
                       input logic [31:0] a);
      @(posedge sys_clk_i);
      #1;
      {req_o, master_o, write_o, excl_o} = {1'b1, m, w, x};
      size_o = s;
      addr_o = a;
      wdata_o = ~a;
      @(posedge sys_clk_i);
      #1;
      req_o = 1'b0;
      addr_o = ~a;
      wdata_o = a;
   endtask
endmodule // sad_master_model

// file: sim/system_address_decoder_tb.sv
// self-checking bench for the system address decoder
`timescale 1ns/1ps
module system_address_decoder_tb;
   import sad_pkg::*;
   localparam logic [5:0] E_ERR = 6'h20, E_CODE = 6'h10, E_SRAM = 6'h08;
   localparam logic [5:0] E_MMR = 6'h04, E_PPB = 6'h02, E_SYS = 6'h01;
   logic sys_clk_i, rst_i, large_flash_i, isram_en_i, cache_en_i;
   logic req, mst, wr, ex, code_sel_o, sram_sel_o, mmr_sel_o, sram_isram_o;
   logic sys_sel_o, ppb_sel_o, write_o, done_o, err_o, excl_ok_o;
   logic [31:0] addr, wdata, addr_o, wdata_o, rom_data_o;
   logic [16:0] sram_addr_o;
   logic [3:0] byte_en_o;
   sad_size_t size;
   sad_target_t target_o;
   int n_mismatch = 0, checks_done = 0;
   sad_master_model u_sad_master_model (.sys_clk_i(sys_clk_i), .req_o(req),
      .master_o(mst), .write_o(wr), .excl_o(ex), .size_o(size),
      .addr_o(addr), .wdata_o(wdata));
   sad_decoder u_sad_decoder (.sys_clk_i, .rst_i, .large_flash_i,
      .isram_en_i, .cache_en_i, .req_i(req), .master_i(mst), .write_i(wr),
      .excl_i(ex), .size_i(size), .addr_i(addr), .wdata_i(wdata),
      .code_sel_o, .sram_sel_o, .mmr_sel_o, .sram_addr_o, .sram_isram_o,
      .sys_sel_o, .ppb_sel_o, .write_o, .addr_o, .wdata_o, .byte_en_o,
      .done_o, .err_o, .excl_ok_o, .rom_data_o, .target_o);
   task automatic ck(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic t(input logic m, w, x, input sad_size_t s,
                    input logic [31:0] a, input logic [5:0] e);
      u_sad_master_model.xfer(m, w, x, s, a);
      ck("done", 32'h1, done_o);
      ck("route", e, {err_o, code_sel_o, sram_sel_o, mmr_sel_o, ppb_sel_o,
         sys_sel_o});
      ck("write", 32'(w && e != E_ERR), write_o);
      ck("addr", a, addr_o);
      ck("wdata", ~a, wdata_o);
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic sc_code();
      large_flash_i = 1'b0;
      t(0, 0, 0, SAD_SIZE_WORD, 32'h0001_FBFC, E_CODE);
      ck("target", SAD_TGT_CODE, target_o);
      t(0, 0, 0, SAD_SIZE_WORD, 32'h0003_FFFC, E_ERR);
      large_flash_i = 1'b1;
      t(0, 0, 0, SAD_SIZE_WORD, 32'h0003_FFFC, E_CODE);
      t(1, 0, 0, SAD_SIZE_WORD, 32'h0000_0000, E_ERR);
      t(0, 1, 0, SAD_SIZE_WORD, 32'h0000_0100, E_ERR);
   endtask
   task automatic sc_sram();
      t(0, 1, 0, SAD_SIZE_WORD, 32'h2000_0004, E_SRAM);
      ck("lanes", 32'hF, byte_en_o);
      ck("offset", 32'h4, sram_addr_o);
      t(1, 0, 0, SAD_SIZE_WORD, 32'h2000_7FFC, E_SRAM);
      t(1, 1, 0, SAD_SIZE_BYTE, 32'h2000_0003, E_SRAM);
      ck("lanes", 32'h8, byte_en_o);
      t(0, 0, 0, SAD_SIZE_HALF, 32'h2000_0002, E_SRAM);
      ck("lanes", 32'hC, byte_en_o);
      t(0, 0, 0, SAD_SIZE_HALF, 32'h2000_0001, E_ERR);
      t(0, 0, 0, SAD_SIZE_WORD, 32'h2004_7FFC, E_MMR);
      ck("target", SAD_TGT_MMR, target_o);
      t(0, 0, 0, SAD_SIZE_BAD, 32'h2000_0000, E_ERR);
      ck("lanes", 32'h0, byte_en_o);
      t(0, 0, 0, SAD_SIZE_WORD, 32'h2004_8000, E_ERR);
   endtask
   task automatic sc_part();
      t(0, 0, 0, SAD_SIZE_WORD, 32'h2001_7FFC, E_SRAM);
      ck("isram", 32'h1, sram_isram_o);
      t(0, 0, 0, SAD_SIZE_WORD, 32'h2000_C000, E_ERR);
      cache_en_i = 1'b1;
      t(0, 0, 0, SAD_SIZE_WORD, 32'h2001_7000, E_ERR);
      cache_en_i = 1'b0;
      isram_en_i = 1'b0;
      t(0, 0, 0, SAD_SIZE_WORD, 32'h2000_FFFC, E_SRAM);
      ck("isram", 32'h0, sram_isram_o);
      isram_en_i = 1'b1;
   endtask
   task automatic sc_sys();
      t(0, 1, 0, SAD_SIZE_WORD, 32'hE000_E000, E_PPB);
      t(1, 0, 0, SAD_SIZE_WORD, 32'hE000_E000, E_ERR);
      t(0, 0, 0, SAD_SIZE_WORD, 32'hE010_0000, E_SYS);
      ck("target", SAD_TGT_SYS, target_o);
      t(0, 0, 0, SAD_SIZE_WORD, 32'h4000_0000, E_ERR);
      ck("target", SAD_TGT_NONE, target_o);
      t(0, 1, 0, SAD_SIZE_WORD, 32'hE00F_F000, E_ERR);
      u_sad_master_model.xfer(0, 0, 0, SAD_SIZE_WORD, 32'hE00F_F000);
      ck("rom", 32'h0000_1001, rom_data_o);
      ck("target", SAD_TGT_ROM, target_o);
      u_sad_master_model.xfer(0, 0, 0, SAD_SIZE_WORD, 32'hE00F_F004);
      ck("rom", 32'h0000_2001, rom_data_o);
      u_sad_master_model.xfer(0, 0, 0, SAD_SIZE_WORD, 32'hE00F_F010);
      ck("rom end", 32'h0, rom_data_o);
   endtask
   task automatic sc_excl();
      t(0, 0, 1, SAD_SIZE_WORD, 32'h2000_0010, E_SRAM);
      t(0, 1, 1, SAD_SIZE_WORD, 32'h2000_0010, E_SRAM);
      ck("excl", 32'h1, excl_ok_o);
      t(0, 1, 1, SAD_SIZE_WORD, 32'h2000_0010, E_SRAM);
      ck("excl", 32'h0, excl_ok_o);
      t(0, 0, 1, SAD_SIZE_WORD, 32'h2000_0020, E_SRAM);
      t(1, 1, 0, SAD_SIZE_WORD, 32'h2000_0020, E_SRAM);
      t(0, 1, 1, SAD_SIZE_WORD, 32'h2000_0020, E_SRAM);
      ck("excl", 32'h0, excl_ok_o);
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {rst_i, large_flash_i, isram_en_i, cache_en_i} = 4'hE;
      repeat (8) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      sc_code();
      sc_sram();
      sc_part();
      sc_sys();
      sc_excl();
      print_verdict();
   end
endmodule // system_address_decoder_tb
